// ===== design/uxr_ext_regs.sv
`timescale 1ns/10ps
module uxr_ext_regs #(
    parameter int FIFO_DEPTH = 64
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [6:0] rx_count,
    input wire logic [6:0] tx_count,
    input wire logic rx_fifo_rd,
    input wire logic tx_fifo_wr,
    input wire logic fifo_two_byte,
    output logic rx_pop,
    output logic rx_data_zero,
    output logic tx_push,
    input wire logic fifo_dma_mode,
    input wire logic rx_trigger,
    input wire logic tx_trigger,
    input wire logic rx_timeout,
    output logic rx_dma_req,
    output logic tx_dma_req,
    output logic rx_timeout_irq,
    input wire logic auto_rts_active,
    output logic auto_rts_mode1,
    output logic soft_reset,
    output logic baud16_tick,
    input wire logic ser_tx_bit,
    input wire logic ser_tx_bit_start,
    input wire logic ser_tx_busy,
    output logic ser_rx_bit,
    output logic sout_pin,
    input wire logic sin_pin
);
    import uxr_pkg::*;

    localparam logic [6:0] DEPTH_W = 7'(FIFO_DEPTH);

    typedef struct packed {
        logic [7:0] scratch;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] hctl;
        logic [7:0] irctl;
        logic [7:0] width;
        logic [7:0] mask_lo;
        logic [7:0] mask_mid;
        logic [3:0] mask_hi;
        logic rx_unf;
        logic tx_ovf;
        logic [15:0] rdata;
        logic [15:0] baud_cnt;
        logic tick;
        logic [3:0] enc_cnt;
        logic sout;
        logic sin_s1;
        logic sin_s2;
    } uxr_state_t;

    uxr_state_t s_q;
    uxr_state_t s_d;
    logic [15:0] divisor;
    logic [6:0] need;
    logic [6:0] tx_free;
    logic under;
    logic over;
    logic rd_rx_stat;
    logic rd_tx_stat;
    logic rx_src;
    logic tx_src;
    logic enc_pulse;
    logic dec_bit;

    // ----------------------------------------------------------------
    // fifo access checks
    // ----------------------------------------------------------------
    // one or two bytes per access, in the dma width too
    assign need = fifo_two_byte ? 7'h02 : 7'h01;
    assign tx_free = DEPTH_W - tx_count;
    assign under = rx_fifo_rd && (rx_count == 7'h00 || (fifo_two_byte && rx_count == 7'h01));
    assign over = tx_fifo_wr && tx_free < need;
    // an underrun leaves the pointer alone and reads zeros
    assign rx_pop = rx_fifo_rd && !under;
    assign rx_data_zero = under;
    assign tx_push = tx_fifo_wr && !over;
    assign rd_rx_stat = reg_rd && reg_addr == OFS_RX_STAT;
    assign rd_tx_stat = reg_rd && reg_addr == OFS_TX_STAT;

    // ----------------------------------------------------------------
    // dma request steering
    // ----------------------------------------------------------------
    always_comb begin
        logic [6:0] dneed;
        dneed = s_q.hctl[HC_DMA_2B] ? 7'h02 : 7'h01;
        // mode 1 waits for the trigger level, mode 0 asks per unit on receive and only when empty on transmit
        if (fifo_dma_mode && s_q.hctl[HC_RX_DMODE]) begin
            rx_src = rx_trigger && rx_count >= dneed;
        end else begin
            rx_src = rx_count >= dneed;
        end
        if (fifo_dma_mode && s_q.hctl[HC_TX_DMODE]) begin
            tx_src = tx_trigger && tx_free >= dneed;
        end else begin
            tx_src = tx_count == 7'h00;
        end
        // timeout flushes a short tail that never reaches the width
        if (!s_q.hctl[HC_TO_DIS] && rx_timeout && rx_count != 7'h00) begin
            rx_src = 1'b1;
        end
    end

    assign rx_dma_req = s_q.hctl[HC_RX_DEN] && rx_src;
    assign tx_dma_req = s_q.hctl[HC_TX_DEN] && tx_src;
    assign rx_timeout_irq = s_q.hctl[HC_TO_DIS] && rx_timeout;
    assign auto_rts_mode1 = auto_rts_active && s_q.hctl[HC_RTS_MODE];
    assign soft_reset = s_q.hctl[HC_SWRST];
    assign divisor = {s_q.div_hi, s_q.div_lo};

    // infrared pulse for a zero bit, first three ticks of sixteen
    assign enc_pulse = ser_tx_busy && !ser_tx_bit && s_q.enc_cnt < ENC_PULSE_TICKS;

    // ----------------------------------------------------------------
    // register file, baud generator, encoder
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.sin_s1 = sin_pin;
        s_d.sin_s2 = s_q.sin_s1;
        // writes; the divisor byte side is guarded by software
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_SCRATCH: s_d.scratch = reg_wdata[7:0];
                OFS_DIV_LO: s_d.div_lo = reg_wdata[7:0];
                OFS_DIV_HI: s_d.div_hi = reg_wdata[7:0];
                OFS_HCTL: s_d.hctl = reg_wdata[7:0];
                OFS_IR_CTL: s_d.irctl = reg_wdata[7:0] & IRC_WR_MASK;
                OFS_IR_WIDTH: s_d.width = reg_wdata[7:0];
                OFS_MASK_LO: s_d.mask_lo = reg_wdata[7:0];
                OFS_MASK_MID: s_d.mask_mid = reg_wdata[7:0];
                OFS_MASK_HI: s_d.mask_hi = reg_wdata[3:0];
                default: ;
            endcase
        end
        // status read clears, a same-cycle event still sets
        if (rd_rx_stat) begin
            s_d.rx_unf = 1'b0;
        end
        if (rd_tx_stat) begin
            s_d.tx_ovf = 1'b0;
        end
        if (under) begin
            s_d.rx_unf = 1'b1;
        end
        if (over) begin
            s_d.tx_ovf = 1'b1;
        end
        // software reset holds all but divisor; the bit itself stays writable
        if (s_q.hctl[HC_SWRST] && s_d.hctl[HC_SWRST]) begin
            s_d.scratch = RST_BYTE;
            s_d.hctl[6:0] = RST_BYTE[6:0];
            s_d.irctl = RST_BYTE;
            s_d.width = RST_WIDTH;
            s_d.mask_lo = RST_BYTE;
            s_d.mask_mid = RST_BYTE;
            s_d.mask_hi = RST_BYTE[3:0];
            s_d.rx_unf = 1'b0;
            s_d.tx_ovf = 1'b0;
        end
        // read data registered; upper byte always zero
        if (reg_rd) begin
            s_d.rdata = 16'h0000;
            unique case (reg_addr)
                OFS_SCRATCH: s_d.rdata[7:0] = s_q.scratch;
                OFS_DIV_LO: s_d.rdata[7:0] = s_q.div_lo;
                OFS_DIV_HI: s_d.rdata[7:0] = s_q.div_hi;
                OFS_HCTL: s_d.rdata[7:0] = s_q.hctl;
                OFS_RX_STAT: s_d.rdata[7:0] = {s_q.rx_unf, rx_count};
                OFS_TX_STAT: s_d.rdata[7:0] = {s_q.tx_ovf, tx_count};
                OFS_IR_CTL: s_d.rdata[7:0] = s_q.irctl;
                OFS_IR_WIDTH: s_d.rdata[7:0] = s_q.width;
                OFS_MASK_LO: s_d.rdata[7:0] = s_q.mask_lo;
                OFS_MASK_MID: s_d.rdata[7:0] = s_q.mask_mid;
                OFS_MASK_HI: s_d.rdata[3:0] = s_q.mask_hi;
                default: ;
            endcase
        end
        // divisor zero stops the tick rather than dividing by 65536
        if (divisor == 16'h0000) begin
            s_d.baud_cnt = 16'h0000;
        end else if (s_q.baud_cnt >= divisor - 16'h0001) begin
            s_d.baud_cnt = 16'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.baud_cnt = s_q.baud_cnt + 16'h0001;
        end
        // bit-phase counter, restarted by the transmitter per bit
        if (ser_tx_bit_start) begin
            s_d.enc_cnt = 4'h0;
        end else if (s_q.tick && s_q.enc_cnt != ENC_LAST_TICK) begin
            s_d.enc_cnt = s_q.enc_cnt + 4'h1;
        end
        // plain line or encoded pulse, polarity per control bit
        if (s_q.irctl[IRC_MODE]) begin
            s_d.sout = enc_pulse ? s_q.irctl[IRC_TX_POL] : !s_q.irctl[IRC_TX_POL];
        end else begin
            s_d.sout = ser_tx_bit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.width <= RST_WIDTH;
            s_q.sout <= 1'b1;
            s_q.sin_s1 <= 1'b1;
            s_q.sin_s2 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // infrared decoder
    // ----------------------------------------------------------------
    uxr_ir_rx u_ir_rx (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ir_in(s_q.sin_s2),
        .rx_polarity(s_q.irctl[IRC_RX_POL]),
        .rx_enable(s_q.irctl[IRC_RX_EN]),
        .mask_disable(s_q.irctl[IRC_MASK_DIS]),
        .pulse_width(s_q.width),
        .mask_period({s_q.mask_hi, s_q.mask_mid, s_q.mask_lo}),
        .tx_busy(ser_tx_busy),
        .rx_bit(dec_bit)
    );

    // decoder sits in the receive path only in infrared mode
    assign ser_rx_bit = s_q.irctl[IRC_MODE] ? dec_bit : s_q.sin_s2;
    assign sout_pin = s_q.sout;
    assign reg_rdata = s_q.rdata;
    assign baud16_tick = s_q.tick;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reserved_zero: assert property (reg_rd |=> reg_rdata[15:8] == 8'h00)
        else $error("reserved bits read non-zero");
    a_scratch_back: assert property (reg_wr && reg_addr == OFS_SCRATCH && !soft_reset
        ##1 !reg_wr ##1 reg_rd && reg_addr == OFS_SCRATCH
        |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3))
        else $error("scratch byte lost");
    a_under_flag: assert property (under |-> !rx_pop ##1 s_q.rx_unf)
        else $error("underrun not flagged or fifo popped");
    a_under_clear: assert property (rd_rx_stat && !under |=> !s_q.rx_unf)
        else $error("underrun flag not cleared by read");
    a_over_drop: assert property (tx_fifo_wr && tx_count == DEPTH_W |-> !tx_push ##1 s_q.tx_ovf)
        else $error("overrun write not dropped");
    a_dma_gate: assert property (!s_q.hctl[HC_RX_DEN] && !s_q.hctl[HC_TX_DEN]
        |-> !rx_dma_req && !tx_dma_req)
        else $error("dma request while disabled");
    a_swrst_hold: assert property (soft_reset && reg_wr && reg_addr == OFS_SCRATCH
        |=> s_q.scratch == RST_BYTE)
        else $error("scratch written during software reset");
    a_baud_period: assert property (baud16_tick && divisor == 16'h0003
        |=> !baud16_tick ##1 !baud16_tick ##1 (baud16_tick || divisor != 16'h0003))
        else $error("tick period does not match divisor");
    a_plain_line: assert property (!s_q.irctl[IRC_MODE] |=> sout_pin == $past(ser_tx_bit))
        else $error("plain mode does not pass transmit bit");
    a_count_read: assert property (reg_rd && reg_addr == OFS_TX_STAT
        |=> reg_rdata[6:0] == $past(tx_count))
        else $error("transmit count misreported");
    c_underrun: cover property (under);
    c_overrun: cover property (over);
    c_ir_pulse: cover property (s_q.irctl[IRC_MODE] && enc_pulse);
    c_rx_dma: cover property (rx_dma_req && s_q.hctl[HC_DMA_2B]);
endmodule : uxr_ext_regs

// ===== design/uxr_ir_rx.sv
`timescale 1ns/10ps
module uxr_ir_rx (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ir_in,
    input wire logic rx_polarity,
    input wire logic rx_enable,
    input wire logic mask_disable,
    input wire logic [7:0] pulse_width,
    input wire logic [19:0] mask_period,
    input wire logic tx_busy,
    output logic rx_bit
);
    import uxr_pkg::*;

    typedef struct packed {
        logic [7:0] run;
        logic [20:0] mask_cnt;
        logic bit_out;
    } uxr_rx_state_t;

    uxr_rx_state_t s_q;
    uxr_rx_state_t s_d;
    logic masked;
    logic active;
    logic [8:0] run_next;

    // ----------------------------------------------------------------
    // echo mask, pulse qualification
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // mask spans transmit plus the extension after it
        masked = !mask_disable && (tx_busy || s_q.mask_cnt != 21'h0_0000);
        if (tx_busy) begin
            s_d.mask_cnt = {1'b0, mask_period} + MASK_EXTRA;
        end else if (s_q.mask_cnt != 21'h0_0000) begin
            s_d.mask_cnt = s_q.mask_cnt - 21'h0_0001;
        end
        active = (ir_in == rx_polarity) && rx_enable && !masked;
        run_next = {1'b0, s_q.run} + 9'h001;
        // saturate so a long pulse stays valid
        if (!active) begin
            s_d.run = 8'h00;
        end else if (s_q.run != 8'hFF) begin
            s_d.run = run_next[7:0];
        end
        s_d.bit_out = !(active && run_next >= {1'b0, pulse_width});
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.bit_out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_bit = s_q.bit_out;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_echo_masked: assert property (tx_busy && !mask_disable |=> rx_bit)
        else $error("pulse accepted during own transmission");
    a_width_valid: assert property (active && run_next >= {1'b0, pulse_width} |=> !rx_bit)
        else $error("valid pulse not decoded as zero");
    a_mask_tail: assert property ($fell(tx_busy) && !mask_disable && mask_period == 20'h0_0000
        |-> masked ##1 masked ##1 !masked || tx_busy || mask_disable)
        else $error("mask extension not two clocks");
    c_valid_pulse: cover property (!rx_bit);
endmodule : uxr_ir_rx

// ===== design/uxr_pkg.sv
// Operation
// - eight-bit scratch byte, read/write, steers nothing in the port
// - reserved upper bits of every sixteen-bit register read as zero
// - sixteen-bit divisor from two bytes divides reference clock into 16x tick
// - software reset bit holds internal registers, not fifo data or divisor
// - rts mode bit picks automatic rts mode 0 or 1
// - dma width bit picks one or two bytes and shapes dma requests
// - timeout dma disable moves receive timeout from dma to interrupt
// - separate receive and transmit dma modes, combined with fifo dma mode
// - each dma request output only when its enable bit is set
// - underrun flag on empty read or two-byte read of one; read clears
// - underrun keeps read pointer, returns zero data, no interrupt
// - seven-bit receive and transmit fifo entry counts readable
// - overrun flag and dropped write when fifo lacks room; read clears
// - infrared mode bit inserts encoder and decoder into serial path
// - separate receive and transmit infrared pulse polarity bits
// - infrared receive enable bit stops or allows reception
// - mask disable bit turns echo masking off
// - pulse valid after width-setting consecutive active samples
// - encoder sends a three-sixteenths bit pulse for each zero bit
// - decoder delivers zero for a valid pulse, otherwise one
// - decoder ignores pulses during own transmission
package uxr_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [31:0] OFS_SCRATCH = 32'h5000_0020;
    localparam logic [31:0] OFS_DIV_LO = 32'h5000_0024;
    localparam logic [31:0] OFS_DIV_HI = 32'h5000_0028;
    localparam logic [31:0] OFS_HCTL = 32'h5000_002C;
    localparam logic [31:0] OFS_RX_STAT = 32'h5000_0030;
    localparam logic [31:0] OFS_TX_STAT = 32'h5000_0034;
    localparam logic [31:0] OFS_IR_CTL = 32'h5000_0040;
    localparam logic [31:0] OFS_IR_WIDTH = 32'h5000_0044;
    localparam logic [31:0] OFS_MASK_LO = 32'h5000_0048;
    localparam logic [31:0] OFS_MASK_MID = 32'h5000_004C;
    localparam logic [31:0] OFS_MASK_HI = 32'h5000_0050;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int HC_SWRST = 7;
    localparam int HC_RTS_MODE = 6;
    localparam int HC_DMA_2B = 5;
    localparam int HC_TO_DIS = 4;
    localparam int HC_RX_DMODE = 3;
    localparam int HC_TX_DMODE = 2;
    localparam int HC_RX_DEN = 1;
    localparam int HC_TX_DEN = 0;
    localparam int IRC_MASK_DIS = 6;
    localparam int IRC_RX_POL = 5;
    localparam int IRC_RX_EN = 4;
    localparam int IRC_TX_POL = 1;
    localparam int IRC_MODE = 0;
    localparam int STAT_FLAG = 7;
    localparam logic [7:0] IRC_WR_MASK = 8'h73;
    // ----------------------------------------------------------------
    // reset values and timing counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_WIDTH = 8'h02;
    localparam logic [3:0] ENC_PULSE_TICKS = 4'h3;
    localparam logic [3:0] ENC_LAST_TICK = 4'hF;
    localparam logic [20:0] MASK_EXTRA = 21'h0_0002;
endpackage : uxr_pkg

// ===== verification/uart_ext_regs_ir_codec_test.sv
`timescale 1ns/10ps
module uart_ext_regs_ir_codec_test;
    import uxr_pkg::*;
    localparam int DEPTH = 64;
    logic sys_clk, sys_rst, reg_wr, reg_rd, rx_fifo_rd, tx_fifo_wr, fifo_two_byte;
    logic fifo_dma_mode, rx_trigger, tx_trigger, rx_timeout, auto_rts_active;
    logic ser_tx_bit, ser_tx_bit_start, ser_tx_busy, sin_pin, rx_pop, rx_data_zero;
    logic tx_push, rx_dma_req, tx_dma_req, rx_timeout_irq, auto_rts_mode1;
    logic soft_reset, baud16_tick, ser_rx_bit, sout_pin, u, seen;
    logic [31:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [6:0] rx_count, tx_count;
    logic [31:0] ofs [11] = '{OFS_SCRATCH, OFS_DIV_LO, OFS_DIV_HI, OFS_HCTL, OFS_RX_STAT,
        OFS_TX_STAT, OFS_IR_CTL, OFS_IR_WIDTH, OFS_MASK_LO, OFS_MASK_MID, OFS_MASK_HI};
    logic [15:0] wm [11] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h0000, 16'h0000,
        16'h0073, 16'h00FF, 16'h00FF, 16'h00FF, 16'h000F};
    logic [15:0] mdl [11];
    // case 5 drops busy with masking on: the two-clock tail must not hide the pulse
    int cctl [7] = '{'h51, 'h51, 'h41, 'h11, 'h51, 'h11, 'h71};
    int clen [7] = '{4, 3, 6, 6, 6, 6, 4};
    int cbsy [7] = '{0, 0, 0, 1, 1, 0, 0};
    int cexp [7] = '{1, 0, 0, 0, 1, 1, 1};
    int err_count = 0, total_checks = 0, cyc = 0, d, n, c;
    logic [15:0] h;
    logic w2, rq, tq;

    uxr_ext_regs #(.FIFO_DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_count(rx_count), .tx_count(tx_count),
        .rx_fifo_rd(rx_fifo_rd), .tx_fifo_wr(tx_fifo_wr), .fifo_two_byte(fifo_two_byte),
        .rx_pop(rx_pop), .rx_data_zero(rx_data_zero), .tx_push(tx_push),
        .fifo_dma_mode(fifo_dma_mode), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
        .rx_timeout(rx_timeout), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req),
        .rx_timeout_irq(rx_timeout_irq), .auto_rts_active(auto_rts_active),
        .auto_rts_mode1(auto_rts_mode1), .soft_reset(soft_reset),
        .baud16_tick(baud16_tick), .ser_tx_bit(ser_tx_bit),
        .ser_tx_bit_start(ser_tx_bit_start), .ser_tx_busy(ser_tx_busy),
        .ser_rx_bit(ser_rx_bit), .sout_pin(sout_pin), .sin_pin(sin_pin));
    uxr_ir_peer peer (.sys_clk(sys_clk), .sin_pin(sin_pin));

    // ----------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // a stuck wait loop would otherwise never reach the verdict
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [15:0] dt);
        tick();
        reg_addr = a;
        reg_wdata = dt;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
    endtask : wr
    // read strobe taken at one edge, data settled just after it
    task automatic rchk(input string nm, input logic [31:0] a, input logic [15:0] e);
        tick();
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk(nm, e, reg_rdata);
    endtask : rchk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {reg_wr, reg_rd, rx_fifo_rd, tx_fifo_wr, fifo_two_byte, fifo_dma_mode} = '0;
        {rx_trigger, tx_trigger, rx_timeout, auto_rts_active, ser_tx_bit_start} = '0;
        {ser_tx_busy, reg_addr, reg_wdata, rx_count, tx_count} = '0;
        ser_tx_bit = 1'b1;
        sys_rst = 1'b1;
        v = $urandom(7280);
        repeat (20) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        for (int i = 0; i < 11; i++) mdl[i] = (i == 7) ? RST_WIDTH : RST_BYTE;
        for (int i = 0; i < 11; i++) rchk("reset_value", ofs[i], mdl[i]);
        // random bytes with dirty upper bits; width kept legal by software
        for (int i = 0; i < 11; i++) begin
            v = $urandom;
            if (i == 3) v[7] = 1'b0;
            if (i == 7 && v[7:1] == 7'h00) v[7:0] = 8'h02;
            if (wm[i] != 16'h0000) wr(ofs[i], v);
            if (wm[i] != 16'h0000) mdl[i] = v & wm[i];
        end
        for (int i = 0; i < 11; i++) rchk("readback", ofs[i], mdl[i]);
        wr(32'h5000_0038, 16'hFFFF);
        rchk("unmapped", 32'h5000_0038, 16'h0000);
        rchk("scratch_kept", OFS_SCRATCH, mdl[0]);
        // software reset holds registers but spares the divisor
        wr(OFS_HCTL, 16'h0080);
        chk("soft_reset", 16'h0001, {15'h0, soft_reset});
        wr(OFS_SCRATCH, 16'h0055);
        rchk("held_scratch", OFS_SCRATCH, 16'h0000);
        rchk("held_width", OFS_IR_WIDTH, 16'h0002);
        rchk("div_kept", OFS_DIV_LO, mdl[1]);
        wr(OFS_HCTL, 16'h0000);
        chk("soft_release", 16'h0000, {15'h0, soft_reset});
        for (int i = 0; i < 11; i++) if (i != 1 && i != 2) mdl[i] = (i == 7) ? 2 : 0;
        rchk("scratch_after", OFS_SCRATCH, 16'h0000);
        wr(OFS_SCRATCH, v);
        rchk("scratch_back", OFS_SCRATCH, v & 16'h00FF);
        // baud tick spacing equals the divisor
        d = 3 + $urandom % 6;
        wr(OFS_DIV_LO, d[15:0]);
        wr(OFS_DIV_HI, 16'h0000);
        n = 0;
        while (baud16_tick !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        tick();
        n = 1;
        while (baud16_tick !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        chk("div_period", d[15:0], n[15:0]);
        // fifo strobes at the empty and full boundaries, status read clears
        for (int k = 0; k < 24; k++) begin
            c = $urandom % 3;
            fifo_two_byte = $urandom;
            rx_count = c[6:0];
            rx_fifo_rd = 1'b1;
            #1 u = (c == 0) || (fifo_two_byte && c == 1);
            chk("rx_pop", {15'h0, !u}, {15'h0, rx_pop});
            chk("rx_data_zero", {15'h0, u}, {15'h0, rx_data_zero});
            tick();
            rx_fifo_rd = 1'b0;
            rchk("rx_status", OFS_RX_STAT, {8'h00, u, c[6:0]});
            c = DEPTH - $urandom % 3;
            tx_count = c[6:0];
            tx_fifo_wr = 1'b1;
            #1 u = (DEPTH - c) < (fifo_two_byte ? 2 : 1);
            chk("tx_push", {15'h0, !u}, {15'h0, tx_push});
            tick();
            tx_fifo_wr = 1'b0;
            rchk("tx_status", OFS_TX_STAT, {8'h00, u, c[6:0]});
        end
        // dma, timeout routing and rts mode against a reference model
        for (int k = 0; k < 40; k++) begin
            h = $urandom & 16'h007F;
            wr(OFS_HCTL, h);
            rx_count = $urandom % 4;
            tx_count = ($urandom % 2) ? 7'd0 : 7'(DEPTH - $urandom % 3);
            {rx_trigger, tx_trigger, rx_timeout, fifo_dma_mode, auto_rts_active} = $urandom;
            #1 w2 = h[5];
            rq = (fifo_dma_mode & h[3]) ? rx_trigger && rx_count >= w2 + 1 : rx_count >= w2 + 1;
            rq = h[1] && (rq || (!h[4] && rx_timeout && rx_count > 0));
            tq = (fifo_dma_mode & h[2]) ? tx_trigger && DEPTH - tx_count >= w2 + 1 : tx_count == 0;
            chk("rx_dma_req", {15'h0, rq}, {15'h0, rx_dma_req});
            chk("tx_dma_req", {15'h0, h[0] && tq}, {15'h0, tx_dma_req});
            chk("timeout_irq", {15'h0, h[4] & rx_timeout}, {15'h0, rx_timeout_irq});
            chk("rts_mode1", {15'h0, h[6] & auto_rts_active}, {15'h0, auto_rts_mode1});
        end
        // plain serial path, then encoder pulse of 3/16 bit
        wr(OFS_IR_CTL, 16'h0000);
        ser_tx_bit = 1'b0;
        tick();
        tick();
        chk("plain_low", 16'h0000, {15'h0, sout_pin});
        ser_tx_bit = 1'b1;
        wr(OFS_IR_CTL, 16'h0043);
        tick();
        chk("ir_idle", 16'h0000, {15'h0, sout_pin});
        ser_tx_busy = 1'b1;
        ser_tx_bit = 1'b0;
        ser_tx_bit_start = 1'b1;
        tick();
        ser_tx_bit_start = 1'b0;
        n = 0;
        repeat (16 * d) begin
            tick();
            if (sout_pin === 1'b1) n++;
        end
        chk("enc_width", 16'h0001, {15'h0, n >= 2 * d && n <= 3 * d + 1});
        ser_tx_busy = 1'b0;
        ser_tx_bit = 1'b1;
        // decoder: width, polarity, enable and echo masking cases
        wr(OFS_IR_WIDTH, 16'h0004);
        for (int k = 0; k < 7; k++) begin
            wr(OFS_IR_CTL, cctl[k][15:0]);
            ser_tx_busy = cbsy[k][0];
            seen = 1'b0;
            fork
                peer.pulse(clen[k], cctl[k][5]);
                begin
                    repeat (6) tick();
                    repeat (clen[k] + 6) begin
                        tick();
                        if (ser_rx_bit === 1'b0) seen = 1'b1;
                    end
                end
            join
            chk("ir_rx", cexp[k][15:0], {15'h0, seen});
        end
        summarize();
    end
endmodule : uart_ext_regs_ir_codec_test

// ===== verification/uxr_ir_peer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far-side infrared transceiver: drives the receive pin
// ----------------------------------------------------------------
module uxr_ir_peer (
    input wire logic sys_clk,
    output logic sin_pin
);
    // line rests high until the first pulse is asked for
    initial begin
        sin_pin = 1'b1;
    end
    // idle for four clocks, active for len clocks, then back to idle
    task automatic pulse(input int len, input logic pol);
        @(posedge sys_clk);
        #1 sin_pin = ~pol;
        repeat (4) @(posedge sys_clk);
        #1 sin_pin = pol;
        repeat (len) @(posedge sys_clk);
        #1 sin_pin = ~pol;
    endtask : pulse
endmodule : uxr_ir_peer
